//--- rx_demod_model.sv
// Model of the demodulator side that feeds receive events to the sequencer.
// Assumes its task is called from the bench, in the ref_clk domain.
`timescale 1ns/100ps
module rx_demod_model
(
   input  wire logic       ref_clk,
   output logic            sync_event,
   output logic [2:0]      sync_word_hit,
   output logic [7:0]      signal_level,
   output logic            header_event,
   output logic [7:0]      header_length,
   output logic            packet_end,
   output logic [7:0]      packet_length,
   output logic            checksum_ok,
   output logic            abort_event
);
   // Events are quiet at start; data fields hold no meaningful value.
   initial
   begin
      {abort_event, packet_end, header_event, sync_event} = 4'h0;
      {sync_word_hit, checksum_ok} = 4'h0;
      {signal_level, header_length, packet_length} = 24'h0;
   end

   // One-cycle event; afterwards the data fields turn to their inverse so stale data never matches.
   task automatic fire(input logic [3:0] ev, input logic [7:0] val, input logic [2:0] hit, input logic ok);
      @(posedge ref_clk);
      {abort_event, packet_end, header_event, sync_event} <= ev;
      {signal_level, header_length, packet_length} <= {val, val, val};
      {sync_word_hit, checksum_ok} <= {hit, ok};
      @(posedge ref_clk);
      {abort_event, packet_end, header_event, sync_event} <= 4'h0;
      {signal_level, header_length, packet_length} <= ~{val, val, val};
      {sync_word_hit, checksum_ok} <= ~{hit, ok};
      #1;
   endtask
endmodule

//--- rx_seq.sv
// Receive sequencing, interrupt flags and packet status for a packet radio.
// Assumes the demodulator supplies one-cycle event pulses on the same clock.
`timescale 1ns/100ps
module rx_seq
   import rx_seq_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              arst_n,
   input  wire logic              receive_command,
   input  wire logic              standby_command,
   input  wire logic [15:0]       timeout_count,
   input  wire logic              timeout_step,
   input  wire logic              irq_routing_command,
   input  wire logic [FLAG_W-1:0] flag_enable_mask,
   input  wire logic [FLAG_W-1:0] line_a_mask,
   input  wire logic [FLAG_W-1:0] line_b_mask,
   input  wire logic [FLAG_W-1:0] line_c_mask,
   input  wire logic              flag_clear_command,
   input  wire logic [FLAG_W-1:0] flag_select_mask,
   input  wire logic              variable_length,
   input  wire logic              checksum_enable,
   input  wire logic              sync_detect_enable,
   input  wire logic [7:0]        max_length,
   input  wire logic [7:0]        rx_base_offset,
   input  wire logic              sync_event,
   input  wire logic [2:0]        sync_word_hit,
   input  wire logic [7:0]        signal_level,
   input  wire logic              header_event,
   input  wire logic [7:0]        header_length,
   input  wire logic              packet_end,
   input  wire logic [7:0]        packet_length,
   input  wire logic              checksum_ok,
   input  wire logic              abort_event,
   input  wire logic              tx_busy,
   input  wire logic              tx_done_event,
   output logic                   irq_line_a,
   output logic                   irq_line_b,
   output logic                   irq_line_c,
   output logic                   receiving,
   output logic                   rc_standby_state,
   output logic                   packet_drop,
   output logic [7:0]             sync_signal_level,
   output logic [7:0]             rx_status_byte,
   output logic [7:0]             tx_status_byte,
   output logic [7:0]             sync_match_byte,
   output logic [7:0]             received_length,
   output logic [7:0]             received_start_offset
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      rx_state_t         state;
      logic [15:0]       timer;
      logic [15:0]       count;
      logic [FLAG_W-1:0] enable;
      logic [FLAG_W-1:0] map_a;
      logic [FLAG_W-1:0] map_b;
      logic [FLAG_W-1:0] map_c;
      logic [FLAG_W-1:0] flags;
      logic [LINE_N-1:0] lines;
      logic              drop;
      logic [7:0]        level;
      logic [7:0]        rx_stat;
      logic [7:0]        tx_stat;
      logic [7:0]        match;
      logic [7:0]        length;
      logic [7:0]        offset;
      logic              rcv;
      logic              stby;
   } seq_t;

   seq_t s_q;
   seq_t s_d;
   logic [FLAG_W-1:0] ev;
   logic              timed;
   logic              expire;
   logic              oversize;

   // Event decode shared by the sequencer and the flag logic.
   always_comb
   begin
      timed    = (s_q.count != TIMEOUT_SINGLE) && (s_q.count != TIMEOUT_CONTINUOUS);
      expire   = (s_q.state == ST_SEARCH) && timed && timeout_step && (s_q.timer == 16'h0001);
      oversize = variable_length && header_event && (header_length > max_length);
      ev = '0;
      ev[FLAG_RX_DONE]  = (s_q.state == ST_PACKET) && packet_end;
      ev[FLAG_SYNC]     = (s_q.state == ST_SEARCH) && sync_event;
      ev[FLAG_CHECKSUM] = ev[FLAG_RX_DONE] && checksum_enable && !checksum_ok;
      ev[FLAG_TIMEOUT]  = expire;
   end

   // Next state: sequencer, timer, flags and status capture.
   always_comb
   begin
      s_d = s_q;
      if (irq_routing_command)
      begin
         s_d.enable = flag_enable_mask;
         s_d.map_a  = line_a_mask;
         s_d.map_b  = line_b_mask;
         s_d.map_c  = line_c_mask;
      end
      s_d.drop = 1'b0;
      unique case (s_q.state)
         ST_STANDBY:
         begin
            if (receive_command)
            begin
               s_d.state = ST_SEARCH;
               s_d.count = timeout_count;
               s_d.timer = timeout_count;
            end
         end
         ST_SEARCH:
         begin
            if (timed && timeout_step && s_q.timer != 16'h0000)
            begin
               s_d.timer = s_q.timer - 16'h0001;
            end
            if (expire)
            begin
               s_d.state = ST_STANDBY;
            end
            else if (sync_event)
            begin
               s_d.state = ST_PACKET;
               s_d.level = signal_level;
               s_d.match = {5'h00, sync_word_hit};
               s_d.rx_stat = BYTE_RESET;
               s_d.rx_stat[RXS_BUSY] = 1'b1;
               s_d.rx_stat[RXS_SYNC] = sync_detect_enable && (sync_word_hit == MATCH_NONE);
            end
         end
         ST_PACKET:
         begin
            if (header_event && variable_length)
            begin
               s_d.rx_stat[RXS_HEADER] = 1'b1;
            end
            if (oversize)
            begin
               s_d.rx_stat[RXS_OVERSIZE] = 1'b1;
               s_d.rx_stat[RXS_BUSY]     = 1'b0;
               s_d.drop  = 1'b1;
               s_d.state = ST_SEARCH;
            end
            else if (abort_event)
            begin
               s_d.rx_stat[RXS_ABORT] = 1'b1;
               s_d.rx_stat[RXS_BUSY]  = 1'b0;
               s_d.state = ST_SEARCH;
            end
            else if (packet_end)
            begin
               s_d.rx_stat[RXS_DONE]     = 1'b1;
               s_d.rx_stat[RXS_BUSY]     = 1'b0;
               s_d.rx_stat[RXS_CHECKSUM] = checksum_enable && !checksum_ok;
               s_d.length = packet_length;
               s_d.offset = rx_base_offset;
               s_d.state  = (s_q.count == TIMEOUT_CONTINUOUS) ? ST_SEARCH : ST_STANDBY;
            end
         end
      endcase
      if (standby_command)
      begin
         s_d.state = ST_STANDBY;
      end
      if (tx_busy)
      begin
         s_d.rx_stat[RXS_BUSY] = 1'b1;
      end
      if (abort_event && tx_busy)
      begin
         s_d.rx_stat[RXS_ABORT] = 1'b1;
      end
      if (tx_done_event)
      begin
         s_d.tx_stat[TXS_SENT] = 1'b1;
      end
      // Clear first so that a same-cycle event wins.
      s_d.flags = (s_q.flags & ~(flag_clear_command ? flag_select_mask : '0))
                  | (ev & s_q.enable);
      s_d.lines[0] = |(s_d.flags & s_d.map_a);
      s_d.lines[1] = |(s_d.flags & s_d.map_b);
      s_d.lines[2] = |(s_d.flags & s_d.map_c);
      // Mode outputs are registered copies of the next state, so no decode sits behind a pin.
      s_d.rcv  = (s_d.state != ST_STANDBY);
      s_d.stby = (s_d.state == ST_STANDBY);
   end

   // State register.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q      <= '0;
         s_q.stby <= 1'b1; // Standby is the state left by reset.
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Output drive straight from the state register.
   assign irq_line_a            = s_q.lines[0];
   assign irq_line_b            = s_q.lines[1];
   assign irq_line_c            = s_q.lines[2];
   assign receiving             = s_q.rcv;
   assign rc_standby_state      = s_q.stby;
   assign packet_drop           = s_q.drop;
   assign sync_signal_level     = s_q.level;
   assign rx_status_byte        = s_q.rx_stat;
   assign tx_status_byte        = s_q.tx_stat;
   assign sync_match_byte       = s_q.match;
   assign received_length       = s_q.length;
   assign received_start_offset = s_q.offset;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_done_flag;
      @(posedge ref_clk) disable iff (!arst_n)
      (ev[FLAG_RX_DONE] && s_q.enable[FLAG_RX_DONE]) |=> s_q.flags[FLAG_RX_DONE];
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("done flag not set");

   property p_sync_flag;
      @(posedge ref_clk) disable iff (!arst_n)
      (s_q.state == ST_SEARCH && sync_event && !expire && s_q.enable[FLAG_SYNC]) |=> s_q.flags[FLAG_SYNC];
   endproperty
   a_sync_flag: assert property (p_sync_flag) else $error("sync flag not set");

   property p_line_a;
      @(posedge ref_clk) disable iff (!arst_n)
      ##1 (irq_line_a == |(s_q.flags & s_q.map_a));
   endproperty
   a_line_a: assert property (p_line_a) else $error("line a not OR of flags");

   property p_single_end;
      @(posedge ref_clk) disable iff (!arst_n)
      (s_q.state == ST_PACKET && packet_end && !oversize && !abort_event && !standby_command
       && s_q.count != TIMEOUT_CONTINUOUS) |=> rc_standby_state;
   endproperty
   a_single_end: assert property (p_single_end) else $error("no standby after packet");

   property p_cont;
      @(posedge ref_clk) disable iff (!arst_n)
      (s_q.state == ST_PACKET && packet_end && !standby_command && s_q.count == TIMEOUT_CONTINUOUS)
      |=> (s_q.state == ST_SEARCH);
   endproperty
   a_cont: assert property (p_cont) else $error("continuous receive stopped");

   property p_timer_hold;
      @(posedge ref_clk) disable iff (!arst_n)
      (s_q.state == ST_PACKET) |=> $stable(s_q.timer);
   endproperty
   a_timer_hold: assert property (p_timer_hold) else $error("timer ran during packet");

   property p_clear;
      @(posedge ref_clk) disable iff (!arst_n)
      (flag_clear_command && flag_select_mask[FLAG_SYNC] && !ev[FLAG_SYNC]) |=> !s_q.flags[FLAG_SYNC];
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");

   property p_sticky;
      @(posedge ref_clk) disable iff (!arst_n)
      (s_q.flags[FLAG_TIMEOUT] && !(flag_clear_command && flag_select_mask[FLAG_TIMEOUT]))
      |=> s_q.flags[FLAG_TIMEOUT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

   property p_length;
      @(posedge ref_clk) disable iff (!arst_n)
      (s_q.state == ST_PACKET && packet_end && !oversize && !abort_event)
      |=> (received_length == $past(packet_length));
   endproperty
   a_length: assert property (p_length) else $error("length not captured");

   property p_drop;
      @(posedge ref_clk) disable iff (!arst_n)
      (s_q.state == ST_PACKET && oversize) |=> (packet_drop && rx_status_byte[RXS_OVERSIZE]);
   endproperty
   a_drop: assert property (p_drop) else $error("oversize not dropped");

   c_timeout: cover property (@(posedge ref_clk) disable iff (!arst_n) expire);
   c_cont:    cover property (@(posedge ref_clk) disable iff (!arst_n)
                              s_q.count == TIMEOUT_CONTINUOUS && ev[FLAG_RX_DONE]);
   c_crc:     cover property (@(posedge ref_clk) disable iff (!arst_n) ev[FLAG_CHECKSUM]);
   c_both:    cover property (@(posedge ref_clk) disable iff (!arst_n) flag_clear_command && |ev);

endmodule

//--- rx_seq_bench.sv
// Self-checking bench for the receive sequencing and status block.
// Assumes rx_seq and the demodulator model; commands are one-cycle pulses.
`timescale 1ns/100ps
module rx_seq_bench;
   import rx_seq_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0;
   logic [5:0] pulses = 6'h0;
   logic [15:0] timeout_count = 16'h0;
   logic [3:0] flag_select_mask = 4'h0;
   logic tx_busy = 1'b0;
   logic [3:0] flag_enable_mask = 4'hf;
   logic variable_length = 1'b1;
   logic checksum_enable = 1'b1;
   logic sync_detect_enable = 1'b1;
   logic sync_event, header_event, packet_end, checksum_ok, abort_event;
   logic [2:0] sync_word_hit;
   logic [7:0] signal_level, header_length, packet_length;
   logic irq_line_a, irq_line_b, irq_line_c, receiving, rc_standby_state, packet_drop;
   logic [7:0] sync_signal_level, rx_status_byte, tx_status_byte, sync_match_byte;
   logic [7:0] received_length, received_start_offset;
   int fail_count = 0;
   int samples_checked = 0;

   // --------------------------------------------------------------
   // Clock, design and demodulator model
   // --------------------------------------------------------------
   // The 40 MHz reference clock.
   always #12.5 ref_clk = ~ref_clk;

   rx_seq i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .receive_command(pulses[0]),
      .standby_command(pulses[1]), .timeout_count(timeout_count), .timeout_step(pulses[3]),
      .irq_routing_command(pulses[5]), .flag_enable_mask(flag_enable_mask), .line_a_mask(4'h1),
      .line_b_mask(4'h6), .line_c_mask(4'h8), .flag_clear_command(pulses[2]),
      .flag_select_mask(flag_select_mask), .variable_length(variable_length),
      .checksum_enable(checksum_enable), .sync_detect_enable(sync_detect_enable),
      .max_length(8'h10), .rx_base_offset(8'h20),
      .sync_event(sync_event), .sync_word_hit(sync_word_hit), .signal_level(signal_level),
      .header_event(header_event), .header_length(header_length), .packet_end(packet_end),
      .packet_length(packet_length), .checksum_ok(checksum_ok), .abort_event(abort_event),
      .tx_busy(tx_busy), .tx_done_event(pulses[4]), .irq_line_a(irq_line_a),
      .irq_line_b(irq_line_b), .irq_line_c(irq_line_c), .receiving(receiving),
      .rc_standby_state(rc_standby_state), .packet_drop(packet_drop),
      .sync_signal_level(sync_signal_level), .rx_status_byte(rx_status_byte),
      .tx_status_byte(tx_status_byte), .sync_match_byte(sync_match_byte),
      .received_length(received_length), .received_start_offset(received_start_offset));

   rx_demod_model i_demod (.ref_clk(ref_clk), .sync_event(sync_event), .sync_word_hit(sync_word_hit),
      .signal_level(signal_level), .header_event(header_event), .header_length(header_length),
      .packet_end(packet_end), .packet_length(packet_length), .checksum_ok(checksum_ok),
      .abort_event(abort_event));

   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   // Command pulse: 0 receive, 1 standby, 2 clear, 3 step, 4 tx done, 5 routing, 6 idle.
   task automatic cmd(input int c);
      @(posedge ref_clk);
      pulses <= 6'h01 << c;
      @(posedge ref_clk);
      pulses <= 6'h00;
      #1;
   endtask

   // Compares a seen value with the expected one.
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Clears the flags in the mask; mask and strobe leave on the same edge.
   task automatic clr(input logic [3:0] m);
      @(posedge ref_clk);
      flag_select_mask <= m;
      pulses           <= 6'h04;
      @(posedge ref_clk);
      pulses <= 6'h00;
      #1;
   endtask

   // Receive command together with its timeout count.
   task automatic start(input logic [15:0] n);
      @(posedge ref_clk);
      timeout_count <= n;
      pulses        <= 6'h01;
      @(posedge ref_clk);
      pulses <= 6'h00;
      #1;
   endtask

   // Loads a flag enable mask and the packet options, with the routing pulse on the same edge.
   task automatic cfg(input logic [3:0] m, input logic f);
      @(posedge ref_clk);
      flag_enable_mask   <= m;
      variable_length    <= f;
      checksum_enable    <= f;
      sync_detect_enable <= f;
      pulses             <= 6'h20;
      @(posedge ref_clk);
      pulses <= 6'h00;
      #1;
   endtask

   // Cuts a hang short.
   initial
   begin
      #(25 * 3000);
      fail_count++;
      complete_run();
   end

   // --------------------------------------------------------------
   // Test sequence
   // --------------------------------------------------------------
   // Walks the timed, single and continuous modes, flags and status bytes.
   initial
   begin
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      #1;
      chk("standby", rc_standby_state, 1'b1);
      cmd(5);
      start(16'h0005);
      chk("receiving", receiving, 1'b1);
      i_demod.fire(4'h1, 8'h50, 3'h2, 1'b1);
      chk("level", sync_signal_level, 8'h50);
      chk("match", sync_match_byte, 8'h02);
      chk("rx_status", rx_status_byte, 8'h01);
      chk("line_b", irq_line_b, 1'b1);
      repeat (6) cmd(3);
      chk("line_c", irq_line_c, 1'b0);
      i_demod.fire(4'h2, 8'h0c, 3'h0, 1'b1);
      chk("header", rx_status_byte[2], 1'b1);
      i_demod.fire(4'h4, 8'h0c, 3'h0, 1'b1);
      chk("standby", rc_standby_state, 1'b1);
      chk("line_a", irq_line_a, 1'b1);
      chk("done", rx_status_byte[1], 1'b1);
      chk("length", received_length, 8'h0c);
      chk("offset", received_start_offset, 8'h20);
      chk("read_end", 16'(received_start_offset) + 16'(received_length), 16'h002c);
      clr(4'h1);
      chk("line_a", irq_line_a, 1'b0);
      chk("line_b", irq_line_b, 1'b1);
      clr(4'hf);
      chk("line_b", irq_line_b, 1'b0);
      start(16'h0002);
      cmd(3);
      chk("line_c", irq_line_c, 1'b0);
      cmd(3);
      chk("line_c", irq_line_c, 1'b1);
      chk("standby", rc_standby_state, 1'b1);
      clr(4'hf);
      start(16'h0000);
      repeat (4) cmd(3);
      chk("line_c", irq_line_c, 1'b0);
      chk("receiving", receiving, 1'b1);
      i_demod.fire(4'h1, 8'h33, 3'h4, 1'b1);
      chk("match", sync_match_byte, 8'h04);
      clr(4'h2);
      chk("line_b", irq_line_b, 1'b0);
      i_demod.fire(4'h4, 8'h07, 3'h0, 1'b0);
      chk("line_b", irq_line_b, 1'b1);
      chk("crc", rx_status_byte[4], 1'b1);
      chk("length", received_length, 8'h07);
      chk("standby", rc_standby_state, 1'b1);
      clr(4'hf);
      start(16'hffff);
      i_demod.fire(4'h1, 8'h11, 3'h0, 1'b1);
      chk("rx_status", rx_status_byte, 8'h41);
      chk("match", sync_match_byte, 8'h00);
      i_demod.fire(4'h4, 8'h05, 3'h0, 1'b1);
      chk("line_a", irq_line_a, 1'b1);
      chk("receiving", receiving, 1'b1);
      clr(4'h1);
      i_demod.fire(4'h1, 8'h22, 3'h1, 1'b1);
      i_demod.fire(4'h2, 8'h20, 3'h0, 1'b1);
      chk("drop", packet_drop, 1'b1);
      chk("oversize", rx_status_byte[5], 1'b1);
      chk("line_a", irq_line_a, 1'b0);
      i_demod.fire(4'h1, 8'h22, 3'h1, 1'b1);
      i_demod.fire(4'h8, 8'h00, 3'h0, 1'b1);
      chk("abort", rx_status_byte[3], 1'b1);
      chk("receiving", receiving, 1'b1);
      // Fixed length, no checksum, no sync check, receive-done flag masked off.
      cfg(4'he, 1'b0);
      i_demod.fire(4'h1, 8'h44, 3'h0, 1'b1);
      chk("rx_status", rx_status_byte, 8'h01);
      i_demod.fire(4'h2, 8'h30, 3'h0, 1'b1);
      chk("drop", packet_drop, 1'b0);
      chk("rx_status", rx_status_byte, 8'h01);
      i_demod.fire(4'h4, 8'h30, 3'h0, 1'b0);
      chk("rx_status", rx_status_byte, 8'h02);
      chk("line_a", irq_line_a, 1'b0);
      chk("length", received_length, 8'h30);
      chk("receiving", receiving, 1'b1);
      cmd(1);
      chk("receiving", receiving, 1'b0);
      cmd(4);
      chk("tx_status", tx_status_byte, 8'h01);
      @(posedge ref_clk);
      tx_busy <= 1'b1;
      cmd(6);
      chk("busy", rx_status_byte[0], 1'b1);
      complete_run();
   end
endmodule

//--- rx_seq_pkg.sv
// Package with constants and types for the receive sequencing and status block.
// Assumes a single 40 MHz clock domain and an asynchronous active-low reset.
package rx_seq_pkg;

   // ------------------------------------------------------------------
   // Timeout count encodings
   // ------------------------------------------------------------------
   localparam logic [15:0] TIMEOUT_SINGLE     = 16'h0000;
   localparam logic [15:0] TIMEOUT_CONTINUOUS = 16'hffff;

   // ------------------------------------------------------------------
   // Interrupt flag bit positions
   // ------------------------------------------------------------------
   localparam int          FLAG_W         = 4;
   localparam int          FLAG_RX_DONE   = 0;
   localparam int          FLAG_SYNC      = 1;
   localparam int          FLAG_CHECKSUM  = 2;
   localparam int          FLAG_TIMEOUT   = 3;
   localparam int          LINE_N         = 3;

   // ------------------------------------------------------------------
   // Status byte field positions and codes
   // ------------------------------------------------------------------
   localparam int          RXS_BUSY       = 0;
   localparam int          RXS_DONE       = 1;
   localparam int          RXS_HEADER     = 2;
   localparam int          RXS_ABORT      = 3;
   localparam int          RXS_CHECKSUM   = 4;
   localparam int          RXS_OVERSIZE   = 5;
   localparam int          RXS_SYNC       = 6;
   localparam int          TXS_SENT       = 0;
   localparam logic [2:0]  MATCH_NONE     = 3'h0;
   localparam logic [2:0]  MATCH_WORD1    = 3'h1;
   localparam logic [2:0]  MATCH_WORD2    = 3'h2;
   localparam logic [2:0]  MATCH_WORD3    = 3'h4;
   localparam logic [7:0]  BYTE_RESET     = 8'h00;

   // Receive sequencer states.
   typedef enum logic [1:0] {ST_STANDBY, ST_SEARCH, ST_PACKET} rx_state_t;

endpackage
